// >>> core/dual_ref_output_filter_offset_regs.vh
// Purpose: Constants for the dual reference output filter and offset stage.
// Assumes: Samples and offsets are in hundredths of a percent of full scale.
// Notes: Time constant index runs 0..30 as 10 us..100 ks in a 1-2-5 sequence.
`ifndef DUAL_REF_OUTPUT_FILTER_OFFSET_REGS_VH
`define DUAL_REF_OUTPUT_FILTER_OFFSET_REGS_VH

// Processing clock and update rates.
`define CLK_PERIOD_NS 100
`define FAST_RATE_HZ 1000000
`define SLOW_RATE_HZ 1000
`define KHZ_DIV (`FAST_RATE_HZ / `SLOW_RATE_HZ)

// Time constant index limits.
`define TC_MAX_IDX 5'd30
`define NORMAL_MIN_TC_IDX 5'd8
`define FAST_MAX_TC_IDX 5'd14
// Log2 of the 1 kHz divide, used to rescale microseconds into slow samples.
`define SLOW_SHIFT_ADJ 6'd10
`define MAX_SHIFT 6'd31

// Reference-locked averaging settings.
`define SYNC_OFF 2'd0
`define SYNC_ON 2'd1
`define SYNC_AUTO 2'd2
// Largest reference-dependent minimum time constant, in microseconds.
`define SYNC_FLOOR_US 40'd100000

// Slope codes: 6, 12, 18 and 24 dB per octave.
`define SLOPE_6DB 2'd0
`define SLOPE_12DB 2'd1
`define SLOPE_18DB 2'd2
`define SLOPE_24DB 2'd3

// Offset enable states; bit 0 enables X, bit 1 enables Y.
`define OFS_NONE 2'd0
`define OFS_X 2'd1
`define OFS_Y 2'd2
`define OFS_XY 2'd3

// Offset range, +-300.00 percent, and reset values.
`define BIAS_LIMIT 18'sd30000
`define BIAS_RESET 16'h0000
`define OFS_RESET `OFS_NONE

`endif

// >>> core/lowpass_stage.v
// Purpose: One first-order exponential low-pass section.
// Assumes: The shift sets the time constant as a power of two in samples.
// Notes: Cascading sections raises the roll-off 6 dB per octave each.
`timescale 1ns/1ps
module lowpass_stage
(
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_reset,
  // Sample stream.
  input wire i_tick,
  input wire [5:0] i_shift,
  input wire signed [15:0] i_sample,
  output wire signed [15:0] o_value
);

  reg signed [47:0] state_q;
  wire signed [48:0] diff;
  wire signed [48:0] step;

  // A 32-bit fraction keeps long time constants from stalling on rounding.
  assign diff = {i_sample[15], i_sample, 32'h00000000} - {state_q[47], state_q};
  assign o_value = state_q[47:32];
  // The error never exceeds the state range, so the top bit of the step may go.
  assign step = diff >>> i_shift;

  // The state moves a power-of-two fraction of the error on each tick.
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
      state_q <= 48'h000000000000;
    else if (i_tick)
      state_q <= state_q + step[47:0];
  end

endmodule // lowpass_stage

// >>> core/dual_ref_output_filter_offset.v
// Purpose: Output filters and offsets for both reference channels.
// Assumes: All control and sample inputs come from logic on i_ref_clk.
// Notes: Channel order is X1, Y1, X2, Y2 throughout.
//
// What this block does
// - Fast mode limits roll-off to 6 or 12 dB per octave.
// - Normal mode offers 6, 12, 18 or 24 dB per octave.
// - Locked averaging off: time constant ignores the reference period.
// - Locked averaging on: time constant is a period multiple, held fixed.
// - Locked averaging rejects time constants below a minimum up to 100 ms.
// - Auto locking recomputes the time constant when the reference changes.
// - Normal mode updates at 1 kHz, time constants 5 ms to 100 ks.
// - Fast mode updates at 1 MHz up to 500 ms, else 1 kHz.
// - Fast mode outputs follow the core up to 500 ms; otherwise the slow path is used.
// - Reference one X or Y offset is added only while enabled.
// - Reference two has its own offsets under the same conditions.
// - Each reference offset enable has none, X, Y and both states.
// - Reference one auto-zero loads negated outputs and enables both offsets.
// - Reference two auto-zero does likewise for its own outputs.
`timescale 1ns/1ps
`include "dual_ref_output_filter_offset_regs.vh"
module dual_ref_output_filter_offset
(
  // Clock and reset.
  input wire i_ref_clk,
  input wire i_reset,
  // Demodulator samples, one strobe per 1 MHz sample.
  input wire i_core_valid,
  input wire signed [15:0] i_x_ref_one,
  input wire signed [15:0] i_y_ref_one,
  input wire signed [15:0] i_x_ref_two,
  input wire signed [15:0] i_y_ref_two,
  // Filter settings.
  input wire i_fast_mode,
  input wire [1:0] i_sync_mode,
  input wire [4:0] i_tc_idx_ref_one,
  input wire [4:0] i_tc_idx_ref_two,
  input wire [1:0] i_slope_ref_one,
  input wire [1:0] i_slope_ref_two,
  input wire [19:0] i_period_us_ref_one,
  input wire [19:0] i_period_us_ref_two,
  // Offset settings.
  input wire i_bias_wr,
  input wire [1:0] i_bias_sel,
  input wire signed [15:0] i_bias_data,
  input wire i_ofs_state_wr_ref_one,
  input wire i_ofs_state_wr_ref_two,
  input wire [1:0] i_ofs_state_data,
  input wire i_auto_zero_ref_one,
  input wire i_auto_zero_ref_two,
  // Filtered outputs.
  output reg signed [16:0] o_x_ref_one,
  output reg signed [16:0] o_y_ref_one,
  output reg signed [16:0] o_x_ref_two,
  output reg signed [16:0] o_y_ref_two,
  output reg o_update_ref_one,
  output reg o_update_ref_two,
  // Status.
  output reg o_fast_path,
  output reg o_fast_rate_ref_one,
  output reg o_fast_rate_ref_two,
  output reg o_tc_rejected_ref_one,
  output reg o_tc_rejected_ref_two,
  output reg [1:0] o_ofs_state_ref_one,
  output reg [1:0] o_ofs_state_ref_two,
  output reg signed [15:0] o_inphase_bias_ref_one,
  output reg signed [15:0] o_quadrature_bias_ref_one,
  output reg signed [15:0] o_inphase_bias_ref_two,
  output reg signed [15:0] o_quadrature_bias_ref_two
);

  // Microseconds for a 1-2-5 time constant index.
  function [39:0] tc_us;
    input [4:0] idx;
    integer k;
    reg [39:0] v;
    begin
      v = (idx % 3 == 0) ? 40'd10 : ((idx % 3 == 1) ? 40'd20 : 40'd50);
      for (k = 0; k < 10; k = k + 1)
        if (k < idx / 3)
          v = v * 40'd10;
      tc_us = v;
    end
  endfunction

  // Position of the highest set bit.
  function [5:0] log2f;
    input [39:0] v;
    integer k;
    reg [5:0] r;
    begin
      r = 6'd0;
      for (k = 0; k < 40; k = k + 1)
        if (v[k])
          r = k[5:0];
      log2f = r;
    end
  endfunction

  // Clamp to the offset range.
  function signed [15:0] sat_bias;
    input signed [17:0] v;
    reg signed [17:0] lim;
    reg signed [17:0] nlim;
    begin
      lim = `BIAS_LIMIT;
      nlim = -lim;
      if (v > lim)
        sat_bias = lim[15:0];
      else if (v < nlim)
        sat_bias = nlim[15:0];
      else
        sat_bias = v[15:0];
    end
  endfunction

  wire signed [15:0] ch_in [0:3];
  wire signed [15:0] stage_out [0:15];
  wire signed [15:0] ch_filt [0:3];
  wire [4:0] tc_idx [0:1];
  wire [19:0] period_us [0:1];
  wire [1:0] slope_in [0:1];
  wire [1:0] auto_zero;
  wire [1:0] state_wr;
  reg [9:0] khz_cnt_q;
  reg khz_tick_q;
  reg core_tick_q;
  reg [1:0] tick_q;
  reg [1:0] fast_rate_q;
  reg [1:0] rejected_q;
  reg [5:0] shift_q [0:1];
  reg [1:0] slope_q [0:1];
  reg [1:0] ofs_state_q [0:1];
  reg signed [15:0] bias_q [0:3];

  assign ch_in[0] = i_x_ref_one;
  assign ch_in[1] = i_y_ref_one;
  assign ch_in[2] = i_x_ref_two;
  assign ch_in[3] = i_y_ref_two;
  assign tc_idx[0] = i_tc_idx_ref_one;
  assign tc_idx[1] = i_tc_idx_ref_two;
  assign period_us[0] = i_period_us_ref_one;
  assign period_us[1] = i_period_us_ref_two;
  assign slope_in[0] = i_slope_ref_one;
  assign slope_in[1] = i_slope_ref_two;
  assign auto_zero = {i_auto_zero_ref_two, i_auto_zero_ref_one};
  assign state_wr = {i_ofs_state_wr_ref_two, i_ofs_state_wr_ref_one};

  // The slow rate counts core strobes so both rates stay phase aligned.
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      khz_cnt_q <= 10'h000;
      khz_tick_q <= 1'b0;
      core_tick_q <= 1'b0;
    end
    else
    begin
      core_tick_q <= i_core_valid;
      khz_tick_q <= i_core_valid && (khz_cnt_q == (`KHZ_DIV - 1));
      if (i_core_valid)
        khz_cnt_q <= (khz_cnt_q == (`KHZ_DIV - 1)) ? 10'h000 : khz_cnt_q + 10'h001;
    end
  end

  genvar r, c, s;
  generate
    for (r = 0; r < 2; r = r + 1)
    begin : g_ref
      reg [19:0] held_q;
      reg [4:0] prev_idx_q;
      reg [1:0] prev_sync_q;
      reg [19:0] per_use;
      reg [39:0] want_us;
      reg [39:0] min_us;
      reg [5:0] lt;
      reg [5:0] lp;
      reg [5:0] raw;
      reg slow;
      reg bad;

      always @*
      begin
        per_use = 20'h00000;
        want_us = tc_us(tc_idx[r]);
        lt = log2f(want_us);
        slow = 1'b0;
        bad = 1'b0;
        min_us = 40'h0000000000;
        lp = 6'd0;
        raw = lt;
        slow = !i_fast_mode || (tc_idx[r] > `FAST_MAX_TC_IDX);
        bad = (tc_idx[r] > `TC_MAX_IDX) || (!i_fast_mode && (tc_idx[r] < `NORMAL_MIN_TC_IDX));
        if (i_sync_mode != `SYNC_OFF)
        begin
          per_use = (i_sync_mode == `SYNC_AUTO) ? period_us[r] : held_q;
          lp = log2f({20'h00000, per_use});
          min_us = ({20'h00000, per_use} < `SYNC_FLOOR_US) ? {20'h00000, per_use} : `SYNC_FLOOR_US;
          bad = bad || (want_us < min_us) || (per_use == 20'h00000);
          raw = (lt > lp) ? lt : lp;
        end
        if (slow)
          raw = (raw > `SLOW_SHIFT_ADJ) ? raw - `SLOW_SHIFT_ADJ : 6'd0;
        if (raw > `MAX_SHIFT)
          raw = `MAX_SHIFT;
      end

      // A rejected setting keeps the last applied time constant.
      always @(posedge i_ref_clk)
      begin
        if (i_reset)
        begin
          held_q <= 20'h00000;
          prev_idx_q <= 5'h00;
          prev_sync_q <= `SYNC_OFF;
          shift_q[r] <= 6'h00;
          slope_q[r] <= `SLOPE_6DB;
          fast_rate_q[r] <= 1'b0;
          rejected_q[r] <= 1'b0;
          tick_q[r] <= 1'b0;
          ofs_state_q[r] <= `OFS_RESET;
        end
        else
        begin
          prev_idx_q <= tc_idx[r];
          prev_sync_q <= i_sync_mode;
          if (i_sync_mode != `SYNC_ON || prev_sync_q != `SYNC_ON || prev_idx_q != tc_idx[r])
            held_q <= period_us[r];
          rejected_q[r] <= bad;
          if (!bad)
            shift_q[r] <= raw;
          if (i_fast_mode && slope_in[r] > `SLOPE_12DB)
            slope_q[r] <= `SLOPE_12DB;
          else
            slope_q[r] <= slope_in[r];
          fast_rate_q[r] <= !slow;
          tick_q[r] <= slow ? khz_tick_q : core_tick_q;
          // auto-zero enables both, winning over a state write
          if (auto_zero[r])
            ofs_state_q[r] <= `OFS_XY;
          else if (state_wr[r])
            ofs_state_q[r] <= i_ofs_state_data;
        end
      end
    end

    for (c = 0; c < 4; c = c + 1)
    begin : g_chan
      reg signed [15:0] cap_q;

      // Samples are only valid on the strobe; the filter ticks two cycles later.
      always @(posedge i_ref_clk)
      begin
        if (i_reset)
          cap_q <= 16'h0000;
        else if (i_core_valid)
          cap_q <= ch_in[c];
      end

      for (s = 0; s < 4; s = s + 1)
      begin : g_stage
        lowpass_stage u_stage
        (
          .i_ref_clk(i_ref_clk),
          .i_reset(i_reset),
          .i_tick(tick_q[c / 2]),
          .i_shift(shift_q[c / 2]),
          .i_sample((s == 0) ? cap_q : stage_out[c * 4 + s - 1]),
          .o_value(stage_out[c * 4 + s])
        );
      end
      assign ch_filt[c] = stage_out[c * 4 + slope_q[c / 2]];

      // Auto-zero beats a manual write that lands in the same cycle.
      always @(posedge i_ref_clk)
      begin
        if (i_reset)
          bias_q[c] <= `BIAS_RESET;
        else if (auto_zero[c / 2])
          bias_q[c] <= sat_bias(-{{2{ch_filt[c][15]}}, ch_filt[c]});
        else if (i_bias_wr && i_bias_sel == c)
          bias_q[c] <= sat_bias({{2{i_bias_data[15]}}, i_bias_data});
      end
    end
  endgenerate

  // reference two uses its own values
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_x_ref_one <= 17'h00000;
      o_y_ref_one <= 17'h00000;
      o_x_ref_two <= 17'h00000;
      o_y_ref_two <= 17'h00000;
      o_update_ref_one <= 1'b0;
      o_update_ref_two <= 1'b0;
    end
    else
    begin
      o_update_ref_one <= tick_q[0];
      o_update_ref_two <= tick_q[1];
      if (tick_q[0])
      begin
        o_x_ref_one <= ch_filt[0] + (ofs_state_q[0][0] ? bias_q[0] : 16'sh0000);
        o_y_ref_one <= ch_filt[1] + (ofs_state_q[0][1] ? bias_q[1] : 16'sh0000);
      end
      if (tick_q[1])
      begin
        o_x_ref_two <= ch_filt[2] + (ofs_state_q[1][0] ? bias_q[2] : 16'sh0000);
        o_y_ref_two <= ch_filt[3] + (ofs_state_q[1][1] ? bias_q[3] : 16'sh0000);
      end
    end
  end

  // Status copies are registered so every output leaves a flip-flop.
  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_fast_path <= 1'b0;
      o_fast_rate_ref_one <= 1'b0;
      o_fast_rate_ref_two <= 1'b0;
      o_tc_rejected_ref_one <= 1'b0;
      o_tc_rejected_ref_two <= 1'b0;
      o_ofs_state_ref_one <= `OFS_RESET;
      o_ofs_state_ref_two <= `OFS_RESET;
      o_inphase_bias_ref_one <= `BIAS_RESET;
      o_quadrature_bias_ref_one <= `BIAS_RESET;
      o_inphase_bias_ref_two <= `BIAS_RESET;
      o_quadrature_bias_ref_two <= `BIAS_RESET;
    end
    else
    begin
      o_fast_path <= i_fast_mode;
      o_fast_rate_ref_one <= fast_rate_q[0];
      o_fast_rate_ref_two <= fast_rate_q[1];
      o_tc_rejected_ref_one <= rejected_q[0];
      o_tc_rejected_ref_two <= rejected_q[1];
      o_ofs_state_ref_one <= ofs_state_q[0];
      o_ofs_state_ref_two <= ofs_state_q[1];
      o_inphase_bias_ref_one <= bias_q[0];
      o_quadrature_bias_ref_one <= bias_q[1];
      o_inphase_bias_ref_two <= bias_q[2];
      o_quadrature_bias_ref_two <= bias_q[3];
    end
  end

endmodule // dual_ref_output_filter_offset

// >>> tb/core_sample_source.sv
// Purpose: Stand-in for the demodulator core, one sample strobe every tenth clock.
// Assumes: The stage captures samples only on the strobe cycle.
// Notes: Off-strobe lines carry other data, so a capture on the wrong cycle shows.
`timescale 1ns/1ps
module core_sample_source
(
  // Clock, reset and level.
  input wire i_ref_clk,
  input wire i_reset,
  input wire signed [15:0] i_level,
  // Sample stream.
  output reg o_core_valid = 1'b0,
  output reg signed [15:0] o_x = 16'sh0000,
  output reg signed [15:0] o_y = 16'sh0000
);
  reg [3:0] phase_q = 4'h0;
  // Strobe and samples move on the falling edge, like all other stimulus.
  always @(negedge i_ref_clk)
  begin
    phase_q <= (i_reset || phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
    o_core_valid <= !i_reset && phase_q == 4'h9;
    o_x <= (phase_q == 4'h9) ? i_level : ~i_level;
    o_y <= (phase_q == 4'h9) ? -i_level : i_level;
  end
endmodule // core_sample_source

// >>> tb/dual_ref_output_filter_offset_chk.sv
// Purpose: Port timing checks for the filter and offset stage.
// Assumes: Index 8 is 5 ms and index 14 is 500 ms on the 1-2-5 ladder.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/1ps
module filt_ofs_chk
(
  // Watched inputs.
  input wire i_ref_clk,
  input wire i_reset,
  input wire i_core_valid,
  input wire i_fast_mode,
  input wire [1:0] i_sync_mode,
  input wire [4:0] i_tc_idx_ref_one,
  input wire i_bias_wr,
  input wire [1:0] i_bias_sel,
  input wire signed [15:0] i_bias_data,
  input wire i_ofs_state_wr_ref_one,
  input wire [1:0] i_ofs_state_data,
  input wire i_auto_zero_ref_one,
  // Watched outputs.
  input wire signed [16:0] o_x_ref_one,
  input wire signed [16:0] o_y_ref_one,
  input wire o_update_ref_one,
  input wire o_update_ref_two,
  input wire o_fast_path,
  input wire o_fast_rate_ref_one,
  input wire o_tc_rejected_ref_one,
  input wire [1:0] o_ofs_state_ref_one,
  input wire signed [15:0] o_inphase_bias_ref_one
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Status answers two edges after a setting (o_fast_path after one), hence the three-cycle windows.
  chk_fast_path_copy: assert property (!$past(i_reset) |-> o_fast_path == $past(i_fast_mode))
    else $error("fast path flag does not follow mode");
  chk_update_cause: assert property ((o_update_ref_one || o_update_ref_two) |-> $past(i_core_valid, 3))
    else $error("update without strobe three cycles earlier");
  chk_fast_rate_on: assert property ((i_fast_mode && i_sync_mode == 2'd0
    && i_tc_idx_ref_one <= 5'd14)[*3] |-> o_fast_rate_ref_one) else $error("fast rate missing");
  chk_fast_rate_off: assert property ((!i_fast_mode || i_tc_idx_ref_one > 5'd14)[*3]
    |-> !o_fast_rate_ref_one) else $error("fast rate where slow is due");
  chk_tc_too_short: assert property ((!i_fast_mode && i_sync_mode == 2'd0
    && i_tc_idx_ref_one < 5'd8)[*3] |-> o_tc_rejected_ref_one) else $error("short time constant taken");
  chk_bias_write: assert property (i_bias_wr && i_bias_sel == 2'd0 && !i_auto_zero_ref_one
    && i_bias_data <= 16'sd30000 && i_bias_data >= -16'sd30000
    |-> ##2 o_inphase_bias_ref_one == $past(i_bias_data, 2)) else $error("offset readback wrong");
  chk_state_write: assert property (i_ofs_state_wr_ref_one && !i_auto_zero_ref_one
    |-> ##2 o_ofs_state_ref_one == $past(i_ofs_state_data, 2)) else $error("enable state wrong");
  chk_auto_zero_en: assert property (i_auto_zero_ref_one |-> ##2 o_ofs_state_ref_one == 2'd3)
    else $error("auto zero left an offset off");
  chk_out_hold: assert property (($changed(o_x_ref_one) || $changed(o_y_ref_one))
    |-> o_update_ref_one) else $error("output moved without update");
endmodule // filt_ofs_chk
bind dual_ref_output_filter_offset filt_ofs_chk chk (.*);

// >>> tb/dual_ref_output_filter_offset_tb_top.sv
// Purpose: Self-checking bench for the dual reference filter and offset stage.
// Assumes: Ladder index 7, 8, 12, 14, 15 mean 2 ms, 5 ms, 100 ms, 500 ms, 1 s.
// Notes: Zero input leaves exactly the enabled offsets at the outputs.
`timescale 1ns/1ps
module dual_ref_output_filter_offset_tb_top;
  reg i_ref_clk = 1'b0;
  reg i_reset = 1'b1;
  reg i_fast_mode = 1'b1;
  reg [1:0] i_sync_mode = 2'd0;
  reg [4:0] i_tc_idx_ref_one = 5'd0;
  wire [4:0] i_tc_idx_ref_two = i_tc_idx_ref_one;
  reg [1:0] i_slope_ref_one = 2'd0;
  wire [1:0] i_slope_ref_two = i_slope_ref_one;
  reg [19:0] i_period_us_ref_one = 20'd1000;
  wire [19:0] i_period_us_ref_two = i_period_us_ref_one;
  reg i_bias_wr = 1'b0;
  reg [1:0] i_bias_sel = 2'd0;
  reg signed [15:0] i_bias_data = 16'sh0000;
  reg i_ofs_state_wr_ref_one = 1'b0;
  reg i_ofs_state_wr_ref_two = 1'b0;
  reg [1:0] i_ofs_state_data = 2'd0;
  reg i_auto_zero_ref_one = 1'b0;
  reg i_auto_zero_ref_two = 1'b0;
  reg signed [15:0] level = 16'sh0000;
  wire i_core_valid;
  wire signed [15:0] i_x_ref_one, i_y_ref_one;
  wire signed [15:0] i_x_ref_two = i_x_ref_one;
  wire signed [15:0] i_y_ref_two = i_y_ref_one;
  wire signed [16:0] o_x_ref_one, o_y_ref_one, o_x_ref_two, o_y_ref_two;
  wire o_update_ref_one, o_update_ref_two, o_fast_path, o_fast_rate_ref_one;
  wire o_fast_rate_ref_two, o_tc_rejected_ref_one, o_tc_rejected_ref_two;
  wire [1:0] o_ofs_state_ref_one, o_ofs_state_ref_two;
  wire signed [15:0] o_inphase_bias_ref_one, o_quadrature_bias_ref_one;
  wire signed [15:0] o_inphase_bias_ref_two, o_quadrature_bias_ref_two;
  integer err_count = 0;
  integer num_checks = 0;
  integer gap = 0;
  integer s;
  core_sample_source core (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_level(level),
    .o_core_valid(i_core_valid), .o_x(i_x_ref_one), .o_y(i_y_ref_one));
  dual_ref_output_filter_offset dut (.*);
  // Free-running 10 MHz clock.
  initial forever #50 i_ref_clk = ~i_ref_clk;
  task final_report;
  begin
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task cmp_val(input [16:0] act, input [16:0] exp);
  begin
    num_checks = num_checks + 1;
    if (act !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD %0t got %h want %h", $time, act, exp);
    end
  end
  endtask
  // Waits for n updates of reference one; gap keeps the last spacing in clocks.
  task wait_upd(input integer n);
    integer k;
    integer last;
  begin
    last = 0;
    for (k = 0; k < 25000 && n > 0; k = k + 1)
    begin
      @(negedge i_ref_clk);
      if (o_update_ref_one === 1'b1)
      begin
        gap = k - last;
        last = k;
        n = n - 1;
      end
    end
    if (n > 0)
    begin
      err_count = err_count + 1;
      $display("BAD %0t no output update", $time);
      final_report;
    end
  end
  endtask
  task put_bias(input [1:0] sel, input signed [15:0] d);
  begin
    @(negedge i_ref_clk);
    i_bias_wr = 1'b1;
    i_bias_sel = sel;
    i_bias_data = d;
    @(negedge i_ref_clk);
    i_bias_wr = 1'b0;
  end
  endtask
  // Bits of which: auto-zero two, auto-zero one, state write two, state write one.
  task pulse_ctl(input [3:0] which, input [1:0] d);
  begin
    @(negedge i_ref_clk);
    {i_auto_zero_ref_two, i_auto_zero_ref_one} = which[3:2];
    {i_ofs_state_wr_ref_two, i_ofs_state_wr_ref_one} = which[1:0];
    i_ofs_state_data = d;
    @(negedge i_ref_clk);
    {i_auto_zero_ref_two, i_auto_zero_ref_one, i_ofs_state_wr_ref_two, i_ofs_state_wr_ref_one} = 4'h0;
  end
  endtask
  // Main sequence; the far end keeps a 1 MHz strobe throughout.
  initial
  begin
    repeat (12) @(negedge i_ref_clk);
    i_reset = 1'b0;
    put_bias(2'd0, 16'sd1234);
    put_bias(2'd1, -16'sd2000);
    put_bias(2'd2, 16'sd32000);
    put_bias(2'd3, -16'sd777);
    cmp_val(o_inphase_bias_ref_two, 16'sd30000);
    for (s = 0; s < 4; s = s + 1)
    begin
      pulse_ctl(4'b0011, s[1:0]);
      wait_upd(2);
      cmp_val(o_x_ref_one, s[0] ? 17'sd1234 : 17'sd0);
      cmp_val(o_y_ref_one, s[1] ? -17'sd2000 : 17'sd0);
      cmp_val(o_x_ref_two, s[0] ? 17'sd30000 : 17'sd0);
      cmp_val(o_y_ref_two, s[1] ? -17'sd777 : 17'sd0);
    end
    $display("offset enable test done");
    i_slope_ref_one = 2'd1;
    i_tc_idx_ref_one = 5'd14;
    repeat (20) @(negedge i_ref_clk);
    wait_upd(2);
    cmp_val(gap, 17'd10);
    cmp_val({o_fast_path, o_fast_rate_ref_two}, 17'd3);
    i_tc_idx_ref_one = 5'd15;
    repeat (20) @(negedge i_ref_clk);
    wait_upd(2);
    cmp_val(gap, 17'd10000);
    i_fast_mode = 1'b0;
    i_slope_ref_one = 2'd3;
    i_tc_idx_ref_one = 5'd8;
    repeat (20) @(negedge i_ref_clk);
    wait_upd(2);
    cmp_val(gap, 17'd10000);
    cmp_val({o_fast_path, o_tc_rejected_ref_one}, 17'd0);
    i_tc_idx_ref_one = 5'd7;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_two, 17'd1);
    $display("rate test done");
    i_period_us_ref_one = 20'd200000;
    i_tc_idx_ref_one = 5'd11;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_one, 17'd0);
    i_sync_mode = 2'd1;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_one, 17'd1);
    i_tc_idx_ref_one = 5'd12;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_one, 17'd0);
    i_sync_mode = 2'd2;
    i_period_us_ref_one = 20'd20000;
    i_tc_idx_ref_one = 5'd10;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_one, 17'd0);
    i_tc_idx_ref_one = 5'd9;
    repeat (4) @(negedge i_ref_clk);
    cmp_val(o_tc_rejected_ref_two, 17'd1);
    $display("locked averaging test done");
    i_fast_mode = 1'b1;
    i_sync_mode = 2'd0;
    i_tc_idx_ref_one = 5'd0;
    i_slope_ref_one = 2'd0;
    level = 16'sd3000;
    wait_upd(200);
    pulse_ctl(4'b0100, 2'd0);
    wait_upd(200);
    pulse_ctl(4'b0100, 2'd0);
    wait_upd(3);
    cmp_val(o_x_ref_one, 17'sd0);
    cmp_val(o_y_ref_one, 17'sd0);
    cmp_val(o_inphase_bias_ref_one > -16'sd3017 && o_inphase_bias_ref_one < -16'sd2983, 1);
    cmp_val(o_quadrature_bias_ref_one < 16'sd3017 && o_quadrature_bias_ref_one > 16'sd2983, 1);
    level = 16'sd32000;
    pulse_ctl(4'b0000, 2'd0);
    wait_upd(200);
    pulse_ctl(4'b1000, 2'd0);
    wait_upd(2);
    cmp_val(o_ofs_state_ref_two, 17'd3);
    cmp_val(o_inphase_bias_ref_two, -16'sd30000);
    cmp_val(o_quadrature_bias_ref_two, 16'sd30000);
    $display("auto zero test done");
    final_report;
  end
endmodule // dual_ref_output_filter_offset_tb_top
